/* fcc_cmd_decode.sv */
// Combinational command code decoder.
// Assumes the code is stable while read; no state is held here.
module fcc_cmd_decode
  import fcc_pkg::*;
(
  fcc_decode_if.decoder dec
);
  always_comb
  begin
    dec.op = FCC_OP_NONE;
    dec.hot_reset = 1'b0;
    dec.known = 1'b1;
    unique case (dec.code)
      FCC_CMD_LOAD_MAIN: dec.op = FCC_OP_LOAD_MAIN;
      FCC_CMD_LOAD_SPARE: dec.op = FCC_OP_LOAD_SPARE;
      FCC_CMD_PROG_ALL: dec.op = FCC_OP_PROG_ALL;
      FCC_CMD_PROG_SPARE: dec.op = FCC_OP_PROG_SPARE;
      FCC_CMD_COPY_BACK: dec.op = FCC_OP_COPY_BACK;
      FCC_CMD_UNLOCK: dec.op = FCC_OP_UNLOCK;
      FCC_CMD_LOCK: dec.op = FCC_OP_LOCK;
      FCC_CMD_LOCK_TIGHT: dec.op = FCC_OP_LOCK_TIGHT;
      FCC_CMD_ERASE_VERIFY: dec.op = FCC_OP_ERASE_VERIFY;
      FCC_CMD_BLOCK_ERASE: dec.op = FCC_OP_BLOCK_ERASE;
      FCC_CMD_MULTI_ERASE: dec.op = FCC_OP_MULTI_ERASE;
      FCC_CMD_ERASE_SUSP: dec.op = FCC_OP_ERASE_SUSP;
      FCC_CMD_ERASE_RESUME: dec.op = FCC_OP_ERASE_RESUME;
      FCC_CMD_CORE_RESET: dec.op = FCC_OP_CORE_RESET;
      FCC_CMD_HOT_RESET: dec.hot_reset = 1'b1;
      FCC_CMD_OTP_ACCESS: dec.op = FCC_OP_OTP_ACCESS;
      default: dec.known = 1'b0;
    endcase
  end

  // Operations during which only the two reset commands get through.
  always_comb
  begin
    unique case (dec.op)
      FCC_OP_LOAD_MAIN, FCC_OP_LOAD_SPARE, FCC_OP_PROG_ALL, FCC_OP_PROG_SPARE,
      FCC_OP_COPY_BACK, FCC_OP_ERASE_VERIFY, FCC_OP_BLOCK_ERASE, FCC_OP_MULTI_ERASE,
      FCC_OP_ERASE_RESUME, FCC_OP_OTP_ACCESS: dec.busy_resettable = 1'b1;
      default: dec.busy_resettable = 1'b0;
    endcase
  end
endmodule : fcc_cmd_decode

/* fcc_core_model.sv */
// Behavioural flash core facing the register block.
// Assumes one-cycle start and abort pulses on pclk; finishes op_cycles + 1 cycles after the start.
module fcc_core_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic core_op_start,
  input wire logic core_op_abort,
  input wire logic [7:0] op_cycles,
  output logic core_op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  logic run_q;
  // A new start wins over an abort, so a reset command runs once the old work is dropped.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
      core_op_done <= 1'b0;
    end
    else
    begin
      core_op_done <= 1'b0;
      if (core_op_start)
      begin
        run_q <= 1'b1;
        cnt_q <= op_cycles;
      end
      else if (core_op_abort)
        run_q <= 1'b0;
      else if (run_q && cnt_q == 8'h00)
      begin
        run_q <= 1'b0;
        core_op_done <= 1'b1;
      end
      else if (run_q)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : fcc_core_model

/* fcc_decode_if.sv */
// Interface carrying a written command code to its decoder and the decoded result back.
// Assumes both ends sit on pclk.
interface fcc_decode_if;
  import fcc_pkg::*;
  logic [15:0] code;
  fcc_op_t op;
  logic hot_reset;
  logic known;
  logic busy_resettable;
  modport decoder (input code, output op, output hot_reset, output known, output busy_resettable);
  modport user (output code, input op, input hot_reset, input known, input busy_resettable);
endinterface : fcc_decode_if

/* fcc_pkg.sv */
// Package for the flash command and configuration register block.
// Assumes an APB master on pclk; register indices are word indices, byte address = 4 * index.
package fcc_pkg;
  localparam logic [15:0] FCC_IDX_CMD = 16'hf220;
  localparam logic [15:0] FCC_IDX_CFG1 = 16'hf221;
  localparam logic [15:0] FCC_IDX_CFG2 = 16'hf222;
  localparam logic [15:0] FCC_IDX_STAT = 16'hf230;
  localparam logic [15:0] FCC_IDX_DONE = 16'hf231;
  localparam logic [15:0] FCC_CMD_RST = 16'h0000;
  localparam logic [15:0] FCC_CFG1_RST = 16'h40c0;
  localparam logic [15:0] FCC_CFG1_WMASK = 16'hfff0;
  localparam logic [15:0] FCC_CMD_LOAD_MAIN = 16'h0000;
  localparam logic [15:0] FCC_CMD_LOAD_SPARE = 16'h0013;
  localparam logic [15:0] FCC_CMD_PROG_ALL = 16'h0080;
  localparam logic [15:0] FCC_CMD_PROG_SPARE = 16'h001a;
  localparam logic [15:0] FCC_CMD_COPY_BACK = 16'h001b;
  localparam logic [15:0] FCC_CMD_UNLOCK = 16'h0023;
  localparam logic [15:0] FCC_CMD_LOCK = 16'h002a;
  localparam logic [15:0] FCC_CMD_LOCK_TIGHT = 16'h002c;
  localparam logic [15:0] FCC_CMD_ERASE_VERIFY = 16'h0071;
  localparam logic [15:0] FCC_CMD_BLOCK_ERASE = 16'h0094;
  localparam logic [15:0] FCC_CMD_MULTI_ERASE = 16'h0095;
  localparam logic [15:0] FCC_CMD_ERASE_SUSP = 16'h00b0;
  localparam logic [15:0] FCC_CMD_ERASE_RESUME = 16'h0030;
  localparam logic [15:0] FCC_CMD_CORE_RESET = 16'h00f0;
  localparam logic [15:0] FCC_CMD_HOT_RESET = 16'h00f3;
  localparam logic [15:0] FCC_CMD_OTP_ACCESS = 16'h0065;
  localparam int FCC_RM_BIT = 15;
  localparam int FCC_BRL_LSB = 12;
  localparam int FCC_BL_LSB = 9;
  localparam int FCC_ECC_BIT = 8;
  localparam int FCC_VALID_STROBE_POLARITY_BIT = 7;
  localparam int FCC_COMPLETION_PIN_POLARITY_BIT = 6;
  localparam int FCC_OE_BIT = 5;
  localparam int FCC_RDYCONF_BIT = 4;
  localparam logic [2:0] FCC_BRL_MIN = 3'h3;
  localparam logic [2:0] FCC_BRL_DEF = 3'h4;
  localparam logic [2:0] FCC_BL_MAX = 3'h4;
  localparam logic [2:0] FCC_BL_DEF = 3'h0;
  localparam logic [3:0] FCC_CMD_OP_W = 4'h0;
  typedef enum logic [3:0] {
    FCC_OP_NONE, FCC_OP_LOAD_MAIN, FCC_OP_LOAD_SPARE, FCC_OP_PROG_ALL, FCC_OP_PROG_SPARE,
    FCC_OP_COPY_BACK, FCC_OP_UNLOCK, FCC_OP_LOCK, FCC_OP_LOCK_TIGHT, FCC_OP_ERASE_VERIFY,
    FCC_OP_BLOCK_ERASE, FCC_OP_MULTI_ERASE, FCC_OP_ERASE_SUSP, FCC_OP_ERASE_RESUME,
    FCC_OP_CORE_RESET, FCC_OP_OTP_ACCESS
  } fcc_op_t;
endpackage : fcc_pkg

/* fcc_regs.sv */
// Command and system configuration registers of a flash device, APB slave.
// Assumes an APB master on pclk and a flash core that reports completion by a one-cycle pulse.
// Function
// - Finished operation sets completion flag to ready.
// - 0000h and 0013h load main or spare.
// - 001Bh starts copy back program.
// - Lock commands accept nothing else while busy.
// - Long operations still accept both reset commands.
// - 00F0h resets core; blocks others while busy.
// - 00F3h acts as a warm reset.
// - Bit 15 selects async or burst reads.
// - Bits 14:12 set latency, minimum code 011.
// - Bits 11:9 set burst length, 101-111 reserved.
// - Bit 8 bypasses error correction.
// - Bit 7 sets ready output polarity.
// - Bit 6 sets completion pin polarity.
// - Both outputs float until enable bit set.
// - Enable bit cleared by cold reset or write.
// - Bit 4 moves ready one clock early.
//
// Register access over APB was chosen for this implementation.
module fcc_regs
  import fcc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic warm_reset_pin_n,
  input wire logic core_op_done,
  input wire logic core_data_valid,
  output logic core_op_start,
  output logic [3:0] core_op_code,
  output logic core_op_abort,
  output logic read_timing_select,
  output logic [2:0] initial_access_latency,
  output logic [2:0] burst_word_count,
  output logic ecc_bypass,
  output logic completion_pin_o,
  output logic completion_pin_oe,
  output logic valid_strobe_o,
  output logic valid_strobe_oe
);
  fcc_decode_if dec ();
  fcc_cmd_decode u_dec (.dec(dec));

  logic rp_meta_q;
  logic rp_sync_q;
  logic dv_meta_q;
  logic dv_sync_q;
  logic dv_late_q;
  logic [15:0] cmd_q;
  logic [15:0] cfg_q;
  logic output_driver_enable_q;
  logic done_flag_q;
  logic busy_q;
  logic busy_resettable_q;
  logic warm_q;
  logic soft_warm;
  logic [15:0] word_addr;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic cmd_wr;
  logic cmd_ok;
  logic [15:0] wval;

  assign word_addr = paddr[17:2];
  assign hit = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0) &&
    (word_addr == FCC_IDX_CMD || word_addr == FCC_IDX_CFG1 || word_addr == FCC_IDX_CFG2 ||
     word_addr == FCC_IDX_STAT || word_addr == FCC_IDX_DONE);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_en = psel && penable && !pwrite && hit;
  assign wval = {pstrb[1] ? pwdata[15:8] : 8'h00, pstrb[0] ? pwdata[7:0] : 8'h00};
  assign cmd_wr = wr_en && word_addr == FCC_IDX_CMD && pstrb[1:0] == 2'h3;
  assign dec.code = pwdata[15:0];
  // Only the resets pass a busy long operation; lock, reset and suspend pass nothing.
  assign cmd_ok = dec.known && (!busy_q ||
    (busy_resettable_q && (dec.op == FCC_OP_CORE_RESET || dec.hot_reset)));
  assign soft_warm = cmd_wr && cmd_ok && dec.hot_reset;

  // Pin sampled through two flops; a low level is a warm reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rp_meta_q <= 1'b1;
      rp_sync_q <= 1'b1;
      dv_meta_q <= 1'b0;
      dv_sync_q <= 1'b0;
      dv_late_q <= 1'b0;
    end
    else
    begin
      rp_meta_q <= warm_reset_pin_n;
      rp_sync_q <= rp_meta_q;
      dv_meta_q <= core_data_valid;
      dv_sync_q <= dv_meta_q;
      dv_late_q <= dv_sync_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      warm_q <= 1'b0;
    else
      warm_q <= !rp_sync_q || soft_warm;
  end

  // Command register and the busy tracking of the accepted operation.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_q <= FCC_CMD_RST;
      busy_q <= 1'b0;
      busy_resettable_q <= 1'b0;
      core_op_start <= 1'b0;
      core_op_code <= FCC_CMD_OP_W;
      core_op_abort <= 1'b0;
    end
    else if (warm_q)
    begin
      cmd_q <= FCC_CMD_RST;
      busy_q <= 1'b0;
      busy_resettable_q <= 1'b0;
      core_op_start <= 1'b0;
      core_op_code <= FCC_CMD_OP_W;
      core_op_abort <= 1'b1;
    end
    else
    begin
      core_op_start <= 1'b0;
      core_op_abort <= 1'b0;
      if (cmd_wr && cmd_ok && !dec.hot_reset)
      begin
        cmd_q <= pwdata[15:0];
        busy_q <= 1'b1;
        busy_resettable_q <= dec.busy_resettable;
        core_op_start <= 1'b1;
        core_op_code <= dec.op;
        core_op_abort <= busy_q;
      end
      else if (core_op_done)
      begin
        busy_q <= 1'b0;
        busy_resettable_q <= 1'b0;
      end
    end
  end

  // Completion flag: done sets ready, a host write of zero makes it busy; the set wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      done_flag_q <= 1'b0;
    else if (warm_q)
      done_flag_q <= 1'b0;
    else if (core_op_done && busy_q)
      done_flag_q <= 1'b1;
    else if (wr_en && word_addr == FCC_IDX_DONE && pstrb[0] && !pwdata[0])
      done_flag_q <= 1'b0;
  end

  // Configuration. Unavailable latency and reserved lengths are refused, keeping the old value.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= FCC_CFG1_RST;
    else if (warm_q)
      cfg_q <= FCC_CFG1_RST;
    else if (wr_en && word_addr == FCC_IDX_CFG1)
    begin
      cfg_q[15] <= pstrb[1] ? wval[15] : cfg_q[15];
      if (pstrb[1] && wval[14:12] >= FCC_BRL_MIN)
        cfg_q[14:12] <= wval[14:12];
      if (pstrb[1] && wval[11:9] <= FCC_BL_MAX)
        cfg_q[11:9] <= wval[11:9];
      cfg_q[8] <= pstrb[1] ? wval[8] : cfg_q[8];
      if (pstrb[0])
        cfg_q[7:4] <= wval[7:4] & FCC_CFG1_WMASK[7:4];
    end
  end

  // Enable survives a warm or hot reset; only a cold reset or a write clears it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      output_driver_enable_q <= 1'b0;
    else if (wr_en && word_addr == FCC_IDX_CFG1 && pstrb[0])
      output_driver_enable_q <= pwdata[FCC_OE_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      read_timing_select <= 1'b0;
      initial_access_latency <= FCC_BRL_DEF;
      burst_word_count <= FCC_BL_DEF;
      ecc_bypass <= 1'b0;
    end
    else
    begin
      read_timing_select <= cfg_q[FCC_RM_BIT];
      initial_access_latency <= cfg_q[FCC_BRL_LSB +: 3];
      burst_word_count <= cfg_q[FCC_BL_LSB +: 3];
      ecc_bypass <= cfg_q[FCC_ECC_BIT];
    end
  end

  // Pin drivers. Early ready leads the data by one clock by taking core_data_valid one flop sooner.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      completion_pin_o <= 1'b0;
      completion_pin_oe <= 1'b0;
      valid_strobe_o <= 1'b0;
      valid_strobe_oe <= 1'b0;
    end
    else
    begin
      completion_pin_oe <= output_driver_enable_q;
      valid_strobe_oe <= output_driver_enable_q;
      completion_pin_o <= !(done_flag_q ^ cfg_q[FCC_COMPLETION_PIN_POLARITY_BIT]);
      valid_strobe_o <= (cfg_q[FCC_RDYCONF_BIT] ? dv_sync_q : dv_late_q) ==
        cfg_q[FCC_VALID_STROBE_POLARITY_BIT];
    end
  end

  // Single wait-free access; unmapped or misaligned addresses answer with an error.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite && hit)
      begin
        unique case (word_addr)
          FCC_IDX_CMD: prdata <= {16'h0000, cmd_q};
          FCC_IDX_CFG1: prdata <= {16'h0000, cfg_q[15:6], output_driver_enable_q,
            cfg_q[4], 4'h0};
          FCC_IDX_STAT: prdata <= {31'h0, busy_q};
          FCC_IDX_DONE: prdata <= {31'h0, done_flag_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  a_ready_at_done: assert property (@(posedge pclk) disable iff (!presetn)
    (core_op_done && busy_q && !warm_q) |=> done_flag_q)
    else $error("completion flag not ready after done");
  a_float_no_enable: assert property (@(posedge pclk) disable iff (!presetn)
    !output_driver_enable_q |=> !completion_pin_oe && !valid_strobe_oe)
    else $error("pin driven while disabled");
  a_lock_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    (busy_q && !busy_resettable_q && cmd_wr && !warm_q) |=> !core_op_start)
    else $error("command accepted during lock or reset");
  a_reset_passes: assert property (@(posedge pclk) disable iff (!presetn)
    (busy_q && busy_resettable_q && cmd_wr && pwdata[15:0] == FCC_CMD_CORE_RESET && !warm_q)
    |=> core_op_start && core_op_abort)
    else $error("core reset refused during long operation");
  a_hot_reset: assert property (@(posedge pclk) disable iff (!presetn)
    soft_warm |=> ##1 (cfg_q == FCC_CFG1_RST && cmd_q == FCC_CMD_RST))
    else $error("hot reset did not restore defaults");
  a_latency_floor: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q[14:12] >= FCC_BRL_MIN)
    else $error("unavailable latency stored");
  a_length_legal: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_q[11:9] <= FCC_BL_MAX)
    else $error("reserved burst length stored");
  a_cfg_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && $past(word_addr) == FCC_IDX_CFG1) |-> prdata[3:0] == 4'h0)
    else $error("reserved low bits read nonzero");
  a_cfg2_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pwrite && $past(word_addr) == FCC_IDX_CFG2) |-> prdata == 32'h0)
    else $error("reserved register read nonzero");
  a_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(done_flag_q) && $stable(cfg_q[6]) |=>
    completion_pin_o == ($past(done_flag_q) == $past(cfg_q[6])))
    else $error("completion pin level wrong");
  a_enable_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (warm_q && !wr_en) |=> $stable(output_driver_enable_q))
    else $error("enable changed by warm reset");
endmodule : fcc_regs

/* tb_fcc_regs.sv */
// Testbench for the command and configuration register block.
// Assumes APB on pclk and the behavioural core model on the far side.
module tb_fcc_regs
  import fcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic warm_reset_pin_n = 1'b1;
  logic core_data_valid = 1'b0;
  logic [7:0] op_cycles = 8'h03;
  logic [31:0] prdata;
  logic pready, pslverr, core_op_done, core_op_start, core_op_abort;
  logic [3:0] core_op_code;
  logic read_timing_select, ecc_bypass;
  logic [2:0] initial_access_latency, burst_word_count;
  logic completion_pin_o, completion_pin_oe, valid_strobe_o, valid_strobe_oe;
  int error_cnt = 0;
  int checks = 0;
  logic [15:0] codes[15] = '{FCC_CMD_LOAD_MAIN, FCC_CMD_LOAD_SPARE, FCC_CMD_PROG_ALL,
    FCC_CMD_PROG_SPARE, FCC_CMD_COPY_BACK, FCC_CMD_UNLOCK, FCC_CMD_LOCK, FCC_CMD_LOCK_TIGHT,
    FCC_CMD_ERASE_VERIFY, FCC_CMD_BLOCK_ERASE, FCC_CMD_MULTI_ERASE, FCC_CMD_ERASE_SUSP,
    FCC_CMD_ERASE_RESUME, FCC_CMD_CORE_RESET, FCC_CMD_OTP_ACCESS};
  fcc_op_t ops[15] = '{FCC_OP_LOAD_MAIN, FCC_OP_LOAD_SPARE, FCC_OP_PROG_ALL, FCC_OP_PROG_SPARE,
    FCC_OP_COPY_BACK, FCC_OP_UNLOCK, FCC_OP_LOCK, FCC_OP_LOCK_TIGHT, FCC_OP_ERASE_VERIFY,
    FCC_OP_BLOCK_ERASE, FCC_OP_MULTI_ERASE, FCC_OP_ERASE_SUSP, FCC_OP_ERASE_RESUME,
    FCC_OP_CORE_RESET, FCC_OP_OTP_ACCESS};

  always #2 pclk = ~pclk;

  fcc_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .warm_reset_pin_n(warm_reset_pin_n),
    .core_op_done(core_op_done), .core_data_valid(core_data_valid),
    .core_op_start(core_op_start), .core_op_code(core_op_code), .core_op_abort(core_op_abort),
    .read_timing_select(read_timing_select), .initial_access_latency(initial_access_latency),
    .burst_word_count(burst_word_count), .ecc_bypass(ecc_bypass),
    .completion_pin_o(completion_pin_o), .completion_pin_oe(completion_pin_oe),
    .valid_strobe_o(valid_strobe_o), .valid_strobe_oe(valid_strobe_oe));

  fcc_core_model core_u (.pclk(pclk), .presetn(presetn), .core_op_start(core_op_start),
    .core_op_abort(core_op_abort), .op_cycles(op_cycles), .core_op_done(core_op_done));

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One idle cycle follows each transfer, so psel is never assigned twice in a time step.
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {14'h0000, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
  endtask : rdc

  task automatic cmd(input logic [15:0] code);
    // The spare buffer fill with ones is the host's duty; this block holds no buffer.
    wr(FCC_IDX_DONE, 32'h0);
    wr(FCC_IDX_CMD, {16'h0000, code});
  endtask : cmd

  task automatic wait_done();
    int n;
    n = 0;
    while (core_op_done !== 1'b1 && n < 400)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n < 400, 1'b1);
    repeat (2) @(posedge pclk);
  endtask : wait_done

  initial
  begin
    #100000;
    error_cnt++;
    stop_test();
  end

  initial
  begin
    logic [31:0] r;
    logic e;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(completion_pin_oe, 1'b0);
    chk(valid_strobe_oe, 1'b0);
    chk(initial_access_latency, 3'h4);
    rdc(FCC_IDX_CFG1, 32'h40c0);
    rdc(FCC_IDX_CMD, 32'h0);
    rdc(FCC_IDX_CFG2, 32'h0);
    apb(1'b0, 16'hf223, 32'h0, r, e);
    chk(e, 1'b1);
    wr(FCC_IDX_CFG1, 32'hffff);
    rdc(FCC_IDX_CFG1, 32'hf1f0);
    chk(read_timing_select, 1'b1);
    chk(initial_access_latency, 3'h7);
    chk(ecc_bypass, 1'b1);
    chk(completion_pin_oe & valid_strobe_oe, 1'b1);
    wr(FCC_IDX_CFG1, 32'h2860);
    rdc(FCC_IDX_CFG1, 32'h7860);
    chk(burst_word_count, 3'h4);
    chk(completion_pin_o, 1'b0);
    chk(valid_strobe_o, 1'b1);
    wr(FCC_IDX_CFG1, 32'h30b0);
    // The output flops follow the stored word at the idle edge, one clock after the write.
    @(posedge pclk);
    chk(initial_access_latency, 3'h3);
    chk(completion_pin_o, 1'b1);
    chk(valid_strobe_o, 1'b0);
    core_data_valid <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(valid_strobe_o, 1'b1);
    core_data_valid <= 1'b0;
    wr(FCC_IDX_CFG1, 32'h40e0);
    for (int i = 0; i < 15; i++)
    begin
      cmd(codes[i]);
      chk(core_op_start, 1'b1);
      chk(core_op_code, ops[i]);
      wait_done();
      rdc(FCC_IDX_DONE, 32'h1);
      rdc(FCC_IDX_CMD, {16'h0000, codes[i]});
    end
    chk(completion_pin_o, 1'b1);
    op_cycles <= 8'hc8;
    wr(FCC_IDX_CFG1, 32'h40f0);
    cmd(FCC_CMD_BLOCK_ERASE);
    cmd(FCC_CMD_PROG_ALL);
    chk(core_op_start, 1'b0);
    cmd(FCC_CMD_CORE_RESET);
    chk(core_op_code, FCC_OP_CORE_RESET);
    cmd(FCC_CMD_HOT_RESET);
    repeat (3) @(posedge pclk);
    rdc(FCC_IDX_CFG1, 32'h40f0);
    wait_done();
    cmd(FCC_CMD_LOCK);
    cmd(FCC_CMD_CORE_RESET);
    chk(core_op_start, 1'b0);
    wait_done();
    cmd(FCC_CMD_HOT_RESET);
    repeat (3) @(posedge pclk);
    rdc(FCC_IDX_CFG1, 32'h40e0);
    wr(FCC_IDX_CFG1, 32'h40f0);
    warm_reset_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    warm_reset_pin_n <= 1'b1;
    repeat (4) @(posedge pclk);
    rdc(FCC_IDX_CFG1, 32'h40e0);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(completion_pin_oe, 1'b0);
    stop_test();
  end
endmodule : tb_fcc_regs
